/* File: design/fcd_bus_cycle.v */
// fcd_bus_cycle: one write or read cycle on the asynchronous flash bus.
// assumes a single system clock; data pins are split in/out/enable.
`timescale 1ns/1ps
`default_nettype none
`include "fcd_defines.vh"
module fcd_bus_cycle #(
  parameter AW = 26,
  parameter DW = 16
) (
  input wire clock,
  input wire nrst,
  input wire start,
  input wire wr,
  input wire [AW-1:0] addr,
  input wire [DW-1:0] wdata,
  input wire [DW-1:0] dq_in,
  output reg done,
  output reg [DW-1:0] rdata,
  output reg [AW-1:0] fl_addr,
  output reg [DW-1:0] dq_out,
  output reg dq_oe,
  output reg ce_n,
  output reg we_n,
  output reg oe_n
);
  localparam integer WP_CYC = (`FCD_T_WP_NS + `FCD_CLK_NS - 1) / `FCD_CLK_NS;
  localparam integer WPH_CYC =
    (`FCD_T_WPH_NS + `FCD_CLK_NS - 1) / `FCD_CLK_NS;
  localparam integer ACC_CYC =
    (`FCD_T_ACC_NS + `FCD_CLK_NS - 1) / `FCD_CLK_NS + 1;
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_STROBE = 2'h1;
  localparam [1:0] S_RECOV = 2'h2;
  reg [1:0] st_q;
  reg [3:0] cnt_q;
  reg wr_q;
  reg [DW-1:0] sync1_q;
  reg [DW-1:0] sync2_q;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= {DW{1'b0}};
      sync2_q <= {DW{1'b0}};
    end else begin
      sync1_q <= dq_in;
      sync2_q <= sync1_q;
    end
  end
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_q <= S_IDLE;
      cnt_q <= 4'h0;
      wr_q <= 1'b0;
      done <= 1'b0;
      rdata <= {DW{1'b0}};
      fl_addr <= {AW{1'b0}};
      dq_out <= {DW{1'b0}};
      dq_oe <= 1'b0;
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
    end else begin
      done <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (start) begin
            // address driven on the same edge that the strobe falls
            fl_addr <= addr;
            dq_out <= wdata;
            dq_oe <= wr;
            wr_q <= wr;
            ce_n <= 1'b0;
            we_n <= ~wr;
            oe_n <= wr;
            cnt_q <= wr ? WP_CYC[3:0] : ACC_CYC[3:0];
            st_q <= S_STROBE;
          end
        end
        S_STROBE: begin
          if (cnt_q > 4'h1) begin
            cnt_q <= cnt_q - 4'h1;
          end else begin
            // strobes rise together, data still held
            ce_n <= 1'b1;
            we_n <= 1'b1;
            oe_n <= 1'b1;
            if (!wr_q) begin
              rdata <= sync2_q;
            end
            cnt_q <= WPH_CYC[3:0];
            st_q <= S_RECOV;
          end
        end
        S_RECOV: begin
          dq_oe <= 1'b0;
          if (cnt_q > 4'h1) begin
            cnt_q <= cnt_q - 4'h1;
          end else begin
            done <= 1'b1;
            st_q <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule // fcd_bus_cycle
`default_nettype wire

/* File: design/fcd_host.v */
// fcd_host: host-side flash command sequencer; turns one request into the
// documented write/read cycle sequence. assumes one 10 MHz clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "fcd_defines.vh"
module fcd_host #(
  parameter AW = 26,
  parameter DW = 16,
  parameter BUF_WORDS = 32
) (
  input wire clock,
  input wire nrst,
  input wire req,
  input wire [3:0] op,
  input wire [AW-1:0] addr,
  input wire [DW-1:0] wdata,
  input wire [5:0] wcount,
  input wire [DW-1:0] buf_data,
  input wire [DW-1:0] dq_in,
  output reg busy,
  output reg ack,
  output reg refused,
  output reg buf_take,
  output reg [DW-1:0] rdata,
  output reg in_bypass,
  output reg in_autosel,
  output reg in_suspend,
  output reg in_erase,
  output wire [AW-1:0] fl_addr,
  output wire [DW-1:0] dq_out,
  output wire dq_oe,
  output wire ce_n,
  output wire we_n,
  output wire oe_n
);
  localparam [2:0] M_READ = 3'h0;
  localparam [2:0] M_AUTOSEL = 3'h1;
  localparam [2:0] M_QUERY = 3'h2;
  localparam [2:0] M_SECURE = 3'h3;
  localparam [2:0] M_ABORT = 3'h4;
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_ISSUE = 2'h1;
  localparam [1:0] S_WAIT = 2'h2;
  localparam [1:0] S_GAP = 2'h3;
  reg [1:0] st_q;
  reg [2:0] mode_q;
  reg [3:0] op_q;
  reg [3:0] step_q;
  reg [5:0] left_q;
  reg [AW-1:0] addr_q;
  reg [DW-1:0] data_q;
  reg cyc_start;
  reg cyc_wr;
  reg [AW-1:0] cyc_addr;
  reg [DW-1:0] cyc_data;
  reg last;
  wire cyc_done;
  wire [DW-1:0] cyc_rdata;
  // unlock/command words carry only the low byte and 11 address bits
  function [AW+DW:0] cmd;
    input [10:0] a;
    input [7:0] d;
    begin
      cmd = {1'b1, {(AW-11){1'b0}}, a, {(DW-8){1'b0}}, d};
    end
  endfunction
  function [AW+DW:0] sect;
    input [AW-1:0] a;
    input [7:0] d;
    begin
      sect = {1'b1, a, {(DW-8){1'b0}}, d};
    end
  endfunction
  // ops that skip the unlock pair: read, reset, query, suspend, resume, bypass exit and program/erase in bypass
  function in_bypass_path;
    input [3:0] o;
    begin
      in_bypass_path = (o == `FCD_OP_READ) || (o == `FCD_OP_RESET) ||
        (o == `FCD_OP_QUERY) || (o == `FCD_OP_SUSPEND) ||
        (o == `FCD_OP_RESUME) || (o == `FCD_OP_BYP_EXIT) ||
        (in_bypass && ((o == `FCD_OP_PROG) || (o == `FCD_OP_CHIP_ERASE) ||
        (o == `FCD_OP_SECT_ERASE)));
    end
  endfunction
  // step table: {write, address, data} and whether step is last
  reg [AW+DW:0] s;
  always @* begin
    s = {1'b0, addr_q, data_q};
    last = 1'b1;
    if (step_q == 4'h0 && !in_bypass_path(op_q)) begin
      s = cmd(`FCD_ADDR_U1, `FCD_D_U1);
      last = 1'b0;
    end else if (step_q == 4'h1 && !in_bypass_path(op_q)) begin
      s = cmd(`FCD_ADDR_U2, `FCD_D_U2);
      last = 1'b0;
    end else begin
      case (op_q)
        `FCD_OP_READ: s = {1'b0, addr_q, data_q};
        `FCD_OP_RESET: s = cmd(11'h000, `FCD_D_RESET);
        `FCD_OP_QUERY: s = cmd(`FCD_ADDR_QRY, `FCD_D_QUERY);
        `FCD_OP_SUSPEND: s = cmd(11'h000, `FCD_D_SUSPEND);
        `FCD_OP_RESUME: s = cmd(11'h000, `FCD_D_RESUME);
        `FCD_OP_AUTOSEL: begin
          if (step_q == 4'h2) begin
            s = cmd(`FCD_ADDR_U1, `FCD_D_AUTOSEL);
            last = 1'b0;
          end else begin
            s = {1'b0, addr_q, data_q};
          end
        end
        `FCD_OP_ABORT: s = cmd(`FCD_ADDR_U1, `FCD_D_RESET);
        `FCD_OP_BYP_ENTER: s = cmd(`FCD_ADDR_U1, `FCD_D_BYPASS);
        `FCD_OP_SEC_ENTER: s = cmd(`FCD_ADDR_U1, `FCD_D_SECURE);
        `FCD_OP_SEC_EXIT: begin
          last = (step_q == 4'h3);
          s = (step_q == 4'h2) ? cmd(`FCD_ADDR_U1, `FCD_D_AUTOSEL) :
            cmd(11'h000, `FCD_D_EXIT);
        end
        `FCD_OP_BYP_EXIT: begin
          last = (step_q == 4'h1);
          s = (step_q == 4'h0) ? cmd(11'h000, `FCD_D_AUTOSEL) :
            cmd(11'h000, `FCD_D_EXIT);
        end
        `FCD_OP_PROG: begin
          last = (step_q == (in_bypass ? 4'h1 : 4'h3));
          s = last ? {1'b1, addr_q, data_q} :
            cmd(`FCD_ADDR_U1, `FCD_D_PROG);
        end
        `FCD_OP_WBUF: begin
          last = (step_q == 4'h5);
          case (step_q)
            4'h2: s = sect(addr_q, `FCD_D_WBUF);
            4'h3: s = {1'b1, addr_q, {(DW-6){1'b0}}, wcount};
            4'h4: s = {1'b1, addr_q | {{(AW-6){1'b0}}, left_q}, buf_data};
            default: s = sect(addr_q, `FCD_D_WCONF);
          endcase
        end
        default: begin // chip and sector erase
          if (in_bypass) begin
            last = (step_q == 4'h1);
            s = (step_q == 4'h0) ? cmd(11'h000, `FCD_D_ERASE) :
              (op_q == `FCD_OP_CHIP_ERASE) ? cmd(11'h000, `FCD_D_CHIP) :
              sect(addr_q, `FCD_D_SECTOR);
          end else begin
            last = (step_q == 4'h5);
            case (step_q)
              4'h2: s = cmd(`FCD_ADDR_U1, `FCD_D_ERASE);
              4'h3: s = cmd(`FCD_ADDR_U1, `FCD_D_U1);
              4'h4: s = cmd(`FCD_ADDR_U2, `FCD_D_U2);
              default: s = (op_q == `FCD_OP_CHIP_ERASE) ?
                cmd(`FCD_ADDR_U1, `FCD_D_CHIP) : sect(addr_q, `FCD_D_SECTOR);
            endcase
          end
        end
      endcase
    end
    cyc_wr = s[AW+DW];
    cyc_addr = s[AW+DW-1:DW];
    cyc_data = s[DW-1:0];
    cyc_start = (st_q == S_ISSUE);
  end
  // legality of a request against the tracked device mode
  reg legal;
  always @* begin
    case (op)
      `FCD_OP_QUERY: legal = !in_bypass &&
        ((mode_q == M_READ) || (mode_q == M_AUTOSEL));
      `FCD_OP_SUSPEND: legal = in_erase && !in_suspend;
      `FCD_OP_RESUME: legal = in_suspend;
      `FCD_OP_BYP_EXIT: legal = in_bypass;
      `FCD_OP_BYP_ENTER: legal = !in_bypass && mode_q == M_READ;
      `FCD_OP_RESET, `FCD_OP_ABORT, `FCD_OP_READ, `FCD_OP_SEC_EXIT:
        legal = 1'b1;
      default: legal = !in_bypass || (op == `FCD_OP_PROG) ||
        (op == `FCD_OP_CHIP_ERASE) || (op == `FCD_OP_SECT_ERASE);
    endcase
  end
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_q <= S_IDLE;
      mode_q <= M_READ;
      op_q <= 4'h0;
      step_q <= 4'h0;
      left_q <= 6'h00;
      addr_q <= {AW{1'b0}};
      data_q <= {DW{1'b0}};
      busy <= 1'b0;
      ack <= 1'b0;
      refused <= 1'b0;
      buf_take <= 1'b0;
      rdata <= {DW{1'b0}};
      in_bypass <= 1'b0;
      in_autosel <= 1'b0;
      in_suspend <= 1'b0;
      in_erase <= 1'b0;
    end else begin
      ack <= 1'b0;
      refused <= 1'b0;
      buf_take <= 1'b0;
      in_autosel <= (mode_q == M_AUTOSEL);
      case (st_q)
        S_IDLE: begin
          if (req && !legal) begin
            refused <= 1'b1;
          end else if (req) begin
            op_q <= op;
            addr_q <= addr;
            data_q <= wdata;
            step_q <= 4'h0;
            left_q <= 6'h00;
            busy <= 1'b1;
            st_q <= S_ISSUE;
          end
        end
        S_ISSUE: st_q <= S_WAIT;
        S_GAP: st_q <= S_ISSUE;
        S_WAIT: begin
          if (cyc_done) begin
            if (!cyc_wr) begin
              rdata <= cyc_rdata;
            end
            if (op_q == `FCD_OP_WBUF && step_q == 4'h4) begin
              buf_take <= 1'b1;
              left_q <= left_q + 6'h01;
            end
            if (op_q == `FCD_OP_WBUF && step_q == 4'h4 && left_q != wcount)
            begin
              st_q <= S_GAP; // gap lets the next buffer word arrive
            end else if (!last) begin
              step_q <= step_q + 4'h1;
              st_q <= S_ISSUE;
            end else begin
              busy <= 1'b0;
              ack <= 1'b1;
              st_q <= S_IDLE;
              case (op_q)
                `FCD_OP_RESET: begin
                  mode_q <= M_READ;
                  in_erase <= 1'b0;
                  in_suspend <= 1'b0;
                end
                `FCD_OP_ABORT: mode_q <= M_READ;
                `FCD_OP_AUTOSEL: mode_q <= M_AUTOSEL;
                `FCD_OP_QUERY: mode_q <= M_QUERY;
                `FCD_OP_SEC_ENTER: mode_q <= M_SECURE;
                `FCD_OP_SEC_EXIT: mode_q <= M_READ;
                `FCD_OP_BYP_ENTER: in_bypass <= 1'b1;
                `FCD_OP_BYP_EXIT: begin
                  in_bypass <= 1'b0;
                  mode_q <= M_READ;
                end
                `FCD_OP_SECT_ERASE: in_erase <= 1'b1;
                `FCD_OP_SUSPEND: in_suspend <= 1'b1;
                `FCD_OP_RESUME: in_suspend <= 1'b0;
                default: mode_q <= mode_q;
              endcase
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
  fcd_bus_cycle #(.AW(AW), .DW(DW)) u_cyc (
    .clock(clock),
    .nrst(nrst),
    .start(cyc_start),
    .wr(cyc_wr),
    .addr(cyc_addr),
    .wdata(cyc_data),
    .dq_in(dq_in),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .fl_addr(fl_addr),
    .dq_out(dq_out),
    .dq_oe(dq_oe),
    .ce_n(ce_n),
    .we_n(we_n),
    .oe_n(oe_n)
  );
endmodule // fcd_host
`default_nettype wire

/* File: dv/fcd_flash_model.sv */
// fcd_flash_model: behavioural flash device on the sequencer's pins.
// assumes split data pins; logs every write cycle for the bench.
`timescale 1ns/1ps
`default_nettype none
module fcd_flash_model #(
  parameter [15:0] MFR_CODE = 16'h5a3c, // arbitrary value
  parameter [15:0] PROT_WORD = 16'h0001,
  parameter SERIAL_BIT = 1'b1
) (
  input wire logic [25:0] fl_addr,
  input wire logic [15:0] dq_out,
  input wire logic dq_oe,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  output logic [15:0] dq_in
);
  logic [25:0] wa [0:255];
  logic [15:0] wd [0:255];
  logic [25:0] la;
  logic [15:0] val;
  logic as_q = 1'b0;
  logic armed = 1'b0;
  int nw = 0;
  wire wl = !we_n && !ce_n;
  wire rd = !oe_n && !ce_n;
  // address on the later falling strobe
  always @(posedge wl) begin
    if (wl === 1'b1) begin
      la = fl_addr;
      armed = 1'b1;
    end
  end
  // data on the first rising strobe; only the low byte decodes
  always @(negedge wl) begin
    if (armed) begin
      wa[nw] = la;
      wd[nw] = dq_out;
      if (nw > 1 && wd[nw-2][7:0] == 8'haa && wd[nw-1][7:0] == 8'h55 &&
          dq_out[7:0] == 8'h90 && la[10:0] == 11'h555)
        as_q = 1'b1;
      if (dq_out[7:0] == 8'hf0)
        as_q = 1'b0;
      nw = nw + 1;
      armed = 1'b0;
    end
  end
  always @* begin
    case (fl_addr[7:0])
      8'h00: val = MFR_CODE;
      8'h02: val = PROT_WORD;
      8'h03: val = {8'h00, SERIAL_BIT, 7'h00};
      default: val = 16'h0000;
    endcase
    if (!as_q)
      val = ~fl_addr[15:0];
  end
  // released bus shows the inverse, never the last word
  assign dq_in = rd ? val : ~val;
endmodule // fcd_flash_model
`default_nettype wire

/* File: dv/fcd_host_chk.sv */
// fcd_host_chk: port assertions for the flash command sequencer.
// assumes it is bound onto fcd_host and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module fcd_host_chk #(
  parameter AW = 26,
  parameter DW = 16
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic req,
  input wire logic busy,
  input wire logic ack,
  input wire logic refused,
  input wire logic buf_take,
  input wire logic [AW-1:0] fl_addr,
  input wire logic [DW-1:0] dq_out,
  input wire logic dq_oe,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  sequence wr_low;
    !we_n && !ce_n && dq_oe;
  endsequence
  sequence wr_rise;
    we_n;
  endsequence
  chk_ack_pulse: assert property (ack |=> !ack)
    else $error("ack wider than one cycle");
  chk_refuse_pulse: assert property (refused |=> !refused)
    else $error("refused wider than one cycle");
  chk_req_taken: assert property (req && !busy |-> ##[1:2] (busy || refused))
    else $error("request neither started nor refused");
  chk_no_contention: assert property (!oe_n |-> !dq_oe && we_n)
    else $error("data driven during a read strobe");
  chk_write_drive: assert property (!we_n |-> wr_low)
    else $error("write strobe without chip select or data");
  chk_write_pulse: assert property ($fell(we_n) |-> wr_low ##1 wr_rise)
    else $error("write pulse not one cycle");
  chk_write_hold: assert property ($rose(we_n) |->
      $stable(fl_addr) && $stable(dq_out))
    else $error("address or data moved at write strobe rise");
  chk_read_access: assert property ($fell(oe_n) |-> (!oe_n && !ce_n) [*2])
    else $error("read strobe shorter than access time");
  chk_take_busy: assert property (buf_take |-> busy && !ack)
    else $error("buffer word taken outside a sequence");
endmodule // fcd_host_chk
bind fcd_host fcd_host_chk #(.AW(AW), .DW(DW)) u_chk (
  .clock(clock),
  .nrst(nrst),
  .req(req),
  .busy(busy),
  .ack(ack),
  .refused(refused),
  .buf_take(buf_take),
  .fl_addr(fl_addr),
  .dq_out(dq_out),
  .dq_oe(dq_oe),
  .ce_n(ce_n),
  .we_n(we_n),
  .oe_n(oe_n)
);
`default_nettype wire

/* File: dv/fcd_host_test.sv */
// fcd_host_test: directed scenarios for the flash command sequencer.
// assumes fcd_flash_model on the pins and the checker bound in.
`timescale 1ns/1ps
`default_nettype none
`include "fcd_defines.vh"
module fcd_host_test;
  localparam [25:0] SA = 26'h0150000;
  localparam [15:0] MFR = 16'h5a3c; // arbitrary value
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic req = 1'b0;
  logic [3:0] op = 4'h0;
  logic [25:0] addr = 26'h0;
  logic [15:0] wdata = 16'h0;
  logic [15:0] buf_data = 16'h0;
  logic [5:0] wcount = 6'h0;
  wire [15:0] dq_in, dq_out, rdata;
  wire [25:0] fl_addr;
  wire busy, ack, refused, buf_take, in_bypass, in_autosel, in_suspend;
  wire in_erase, dq_oe, ce_n, we_n, oe_n;
  int mismatches = 0;
  int n_compared = 0;
  int base;
  logic [25:0] qa[$];
  logic [15:0] qd[$];
  int qm[$];
  always #50 clock = ~clock;
  always @(posedge clock)
    if (buf_take === 1'b1)
      buf_data <= buf_data + 16'h0001;
  fcd_host DUT (
    .clock(clock), .nrst(nrst), .req(req), .op(op), .addr(addr),
    .wdata(wdata), .wcount(wcount), .buf_data(buf_data), .dq_in(dq_in),
    .busy(busy), .ack(ack), .refused(refused), .buf_take(buf_take),
    .rdata(rdata), .in_bypass(in_bypass), .in_autosel(in_autosel),
    .in_suspend(in_suspend), .in_erase(in_erase), .fl_addr(fl_addr),
    .dq_out(dq_out), .dq_oe(dq_oe), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n)
  );
  fcd_flash_model #(.MFR_CODE(MFR)) flash (
    .fl_addr(fl_addr), .dq_out(dq_out), .dq_oe(dq_oe), .ce_n(ce_n),
    .we_n(we_n), .oe_n(oe_n), .dq_in(dq_in)
  );
  task tally_and_finish;
    if (mismatches == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task cmp(input string what, input logic [25:0] e, input logic [25:0] g);
    n_compared++;
    if (e !== g) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  // mode 0 command, 1 sector, 2 full word, 3 address free
  task ex(input logic [25:0] a, input logic [15:0] d, input int m);
    qa.push_back(a);
    qd.push_back(d);
    qm.push_back(m);
  endtask
  task unl;
    ex(26'h555, 16'haa, 0);
    ex(26'h2aa, 16'h55, 0);
  endtask
  task run(input logic [3:0] o, input logic [25:0] a, input logic [15:0] d,
      input logic r);
    int n;
    logic [25:0] am;
    logic [15:0] dm;
    base = flash.nw;
    @(posedge clock);
    req <= 1'b1;
    op <= o;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    req <= 1'b0;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (ack !== 1'b1 && refused !== 1'b1 && n < 400);
    cmp("refused", r, refused);
    cmp("ack", !r, ack);
    cmp("writes", 26'(qa.size()), 26'(flash.nw - base));
    for (int k = 0; k < qa.size() && base + k < flash.nw; k++) begin
      am = qm[k] == 0 ? 26'h7ff : qm[k] == 3 ? 26'h0 : '1;
      dm = qm[k] == 2 ? 16'hffff : 16'h00ff;
      cmp("waddr", qa[k] & am, flash.wa[base + k] & am);
      cmp("wdata", {10'h0, qd[k] & dm}, {10'h0, flash.wd[base + k] & dm});
    end
    qa.delete();
    qd.delete();
    qm.delete();
  endtask
  task t_rst;
    ex(26'h0, 16'hf0, 3);
    run(`FCD_OP_RESET, 26'h0, 16'h0, 1'b0);
  endtask
  task t_read;
    run(`FCD_OP_READ, 26'h0012345, 16'h0, 1'b0);
    cmp("read data", {10'h0, ~16'h2345}, {10'h0, rdata});
  endtask
  task t_ident;
    logic [25:0] at [0:2];
    logic [15:0] ad [0:2];
    at = '{26'h0, SA | 26'h2, 26'h3};
    ad = '{MFR, 16'h0001, 16'h0080};
    for (int i = 0; i < 3; i++) begin
      unl();
      ex(26'h555, 16'h90, 0);
      run(`FCD_OP_AUTOSEL, at[i], 16'h0, 1'b0);
      cmp("id word", {10'h0, ad[i]}, {10'h0, rdata});
    end
    cmp("autoselect", 1'b1, in_autosel);
    t_rst();
    // mode flag follows the tracked mode one cycle later
    @(negedge clock);
    cmp("autoselect", 1'b0, in_autosel);
    ex(26'h055, 16'h98, 0);
    run(`FCD_OP_QUERY, 26'h0, 16'h0, 1'b0);
  endtask
  task t_prog;
    unl();
    ex(26'h555, 16'ha0, 0);
    ex(26'h2123456, 16'hbeef, 2);
    run(`FCD_OP_PROG, 26'h2123456, 16'hbeef, 1'b0);
  endtask
  task t_wbuf;
    @(posedge clock);
    wcount <= 6'h3;
    buf_data <= 16'h1000;
    unl();
    ex(SA | 26'h10, 16'h25, 1);
    ex(SA | 26'h10, 16'h03, 1);
    for (int i = 0; i < 4; i++)
      ex(SA | 26'h10 | 26'(i), 16'h1000 + 16'(i), 2);
    ex(SA | 26'h10, 16'h29, 1);
    run(`FCD_OP_WBUF, SA | 26'h10, 16'h0, 1'b0);
    unl();
    ex(26'h555, 16'hf0, 0);
    run(`FCD_OP_ABORT, 26'h0, 16'h0, 1'b0);
  endtask
  task t_bypass;
    unl();
    ex(26'h555, 16'h20, 0);
    run(`FCD_OP_BYP_ENTER, 26'h0, 16'h0, 1'b0);
    cmp("bypass", 1'b1, in_bypass);
    run(`FCD_OP_BYP_ENTER, 26'h0, 16'h0, 1'b1);
    run(`FCD_OP_QUERY, 26'h0, 16'h0, 1'b1);
    ex(26'h0, 16'ha0, 3);
    ex(26'h2000100, 16'h1234, 2);
    run(`FCD_OP_PROG, 26'h2000100, 16'h1234, 1'b0);
    ex(26'h0, 16'h80, 3);
    ex(SA, 16'h30, 1);
    run(`FCD_OP_SECT_ERASE, SA, 16'h0, 1'b0);
    ex(26'h0, 16'h80, 3);
    ex(26'h0, 16'h10, 3);
    run(`FCD_OP_CHIP_ERASE, 26'h0, 16'h0, 1'b0);
    ex(26'h0, 16'h90, 3);
    ex(26'h0, 16'h00, 3);
    run(`FCD_OP_BYP_EXIT, 26'h0, 16'h0, 1'b0);
    cmp("bypass", 1'b0, in_bypass);
    run(`FCD_OP_BYP_EXIT, 26'h0, 16'h0, 1'b1);
    t_rst();
  endtask
  task erase6(input logic [25:0] a, input logic [15:0] d, input int m);
    unl();
    ex(26'h555, 16'h80, 0);
    unl();
    ex(a, d, m);
  endtask
  task t_erase;
    run(`FCD_OP_SUSPEND, 26'h0, 16'h0, 1'b1);
    run(`FCD_OP_RESUME, 26'h0, 16'h0, 1'b1);
    erase6(26'h555, 16'h10, 0);
    run(`FCD_OP_CHIP_ERASE, 26'h0, 16'h0, 1'b0);
    run(`FCD_OP_SUSPEND, 26'h0, 16'h0, 1'b1);
    t_rst();
    erase6(SA, 16'h30, 1);
    run(`FCD_OP_SECT_ERASE, SA, 16'h0, 1'b0);
    cmp("erase", 1'b1, in_erase);
    ex(26'h0, 16'hb0, 3);
    run(`FCD_OP_SUSPEND, 26'h0, 16'h0, 1'b0);
    cmp("suspend", 1'b1, in_suspend);
    ex(26'h0, 16'h30, 3);
    run(`FCD_OP_RESUME, 26'h0, 16'h0, 1'b0);
    cmp("suspend", 1'b0, in_suspend);
    t_rst();
    cmp("erase", 1'b0, in_erase);
  endtask
  task t_secure;
    unl();
    ex(26'h555, 16'h88, 0);
    run(`FCD_OP_SEC_ENTER, 26'h0, 16'h0, 1'b0);
    unl();
    ex(26'h555, 16'h90, 0);
    ex(26'h0, 16'h00, 3);
    run(`FCD_OP_SEC_EXIT, 26'h0, 16'h0, 1'b0);
  endtask
  initial begin
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    t_read();
    t_ident();
    t_prog();
    t_wbuf();
    t_bypass();
    t_erase();
    t_secure();
    tally_and_finish();
  end
  // some thirty sequences of under 60 cycles fit well inside 10000 cycles
  initial begin
    #1000000;
    mismatches++;
    tally_and_finish();
  end
endmodule // fcd_host_test
`default_nettype wire

/* File: inc/fcd_defines.vh */
// fcd_defines.vh: command codes, unlock addresses and bus timings in ns
// for the flash command sequencer; assumes a 10 MHz system clock.
`ifndef FCD_DEFINES_VH
`define FCD_DEFINES_VH
`define FCD_CLK_NS 100
`define FCD_ADDR_U1 11'h555
`define FCD_ADDR_U2 11'h2aa
`define FCD_ADDR_QRY 11'h055
`define FCD_D_U1 8'haa
`define FCD_D_U2 8'h55
`define FCD_D_RESET 8'hf0
`define FCD_D_AUTOSEL 8'h90
`define FCD_D_QUERY 8'h98
`define FCD_D_PROG 8'ha0
`define FCD_D_WBUF 8'h25
`define FCD_D_WCONF 8'h29
`define FCD_D_BYPASS 8'h20
`define FCD_D_ERASE 8'h80
`define FCD_D_CHIP 8'h10
`define FCD_D_SECTOR 8'h30
`define FCD_D_SUSPEND 8'hb0
`define FCD_D_RESUME 8'h30
`define FCD_D_SECURE 8'h88
`define FCD_D_EXIT 8'h00
// autoselect word offsets
`define FCD_AS_MFR 8'h00
`define FCD_AS_DEV1 8'h01
`define FCD_AS_PROT 8'h02
`define FCD_AS_SECURE 8'h03
`define FCD_AS_DEV2 8'h0e
`define FCD_AS_DEV3 8'h0f
// bus strobe timing, ns (write pulse, pulse high, read access)
`define FCD_T_WP_NS 35
`define FCD_T_WPH_NS 30
`define FCD_T_ACC_NS 110
// operation codes on the host command port
`define FCD_OP_READ 4'h0
`define FCD_OP_RESET 4'h1
`define FCD_OP_AUTOSEL 4'h2
`define FCD_OP_QUERY 4'h3
`define FCD_OP_PROG 4'h4
`define FCD_OP_WBUF 4'h5
`define FCD_OP_ABORT 4'h6
`define FCD_OP_BYP_ENTER 4'h7
`define FCD_OP_BYP_EXIT 4'h8
`define FCD_OP_CHIP_ERASE 4'h9
`define FCD_OP_SECT_ERASE 4'ha
`define FCD_OP_SUSPEND 4'hb
`define FCD_OP_RESUME 4'hc
`define FCD_OP_SEC_ENTER 4'hd
`define FCD_OP_SEC_EXIT 4'he
`endif
